// >>> dim_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dim_link_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;
  // Open-drain wires with pull-ups: any enabled driver wins.
  assign scl = m_scl_oe ? m_scl_o : 1'b1;
  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);
  modport master (
    output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe,
    input  scl, sda
  );
  modport slave (
    output s_sda_o, s_sda_oe,
    input  scl, sda
  );
endinterface
`default_nettype wire

// >>> dim_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dim_link_monitor
  import dim_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe
);
  logic       scl_q, sda_q, ack_hi, first, rd, ign, nak;
  logic       rise, start, stop, slave_rx;
  logic [3:0] cnt;
  logic [7:0] sh;
  assign rise     = scl & ~scl_q;
  assign start    = scl & scl_q & sda_q & ~sda;
  assign stop     = scl & scl_q & ~sda_q & sda;
  assign slave_rx = first ? (sh[7:1] == DIM_ADDR_BASE) : (!rd && !ign);
  // Tracks bit position, direction and refusals of the current frame.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      {scl_q, sda_q} <= 2'b11;
      {ack_hi, first, rd, ign, nak} <= '0;
      cnt <= 4'h0;
      sh <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start || stop) begin
        {ack_hi, rd, ign, nak} <= '0;
        first <= start;
        cnt <= 4'h0;
      end else if (rise) begin
        cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
        sh <= (cnt == 4'h8) ? sh : {sh[6:0], sda};
        ack_hi <= (cnt == 4'h8);
      end else if (scl_q && !scl) begin
        ack_hi <= 1'b0;
        if (ack_hi && first) begin
          rd <= sh[0];
          ign <= (sh[7:1] != DIM_ADDR_BASE);
        end
        if (ack_hi) first <= 1'b0;
        if (ack_hi && !first && rd && sda_q) nak <= 1'b1;
      end
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sda_stable_a: assert property (scl && scl_q && (sda != sda_q)
    |-> cnt <= 4'h1 && !ack_hi) else $error("data moved under high clock");
  whole_byte_a: assert property (stop |-> cnt == 4'h1)
    else $error("stop inside a byte");
  slave_ack_a: assert property (ack_hi && slave_rx |-> !sda)
    else $error("addressed receiver did not acknowledge");
  sender_free_a: assert property (ack_hi
    |-> !((first || !rd) ? m_sda_oe : s_sda_oe))
    else $error("sender held data in acknowledge slot");
  // The cycle of the acknowledge rise comes before ack_hi is registered.
  dir_bit_a: assert property ((first || !rd) && scl && scl_q
    && !ack_hi |-> !s_sda_oe) else $error("device drove data while receiving");
  ack_pulse_a: assert property ($rose(scl) |-> scl[*8])
    else $error("clock pulse too short");
  bus_idle_a: assert property (stop |=> (scl && sda)[*8])
    else $error("bus not idle after stop");
  nack_free_a: assert property (nak |-> !s_sda_oe)
    else $error("device drove data after no acknowledge");
  foreign_addr_a: assert property (ign || (ack_hi && first
    && sh[7:1] != DIM_ADDR_BASE) |-> !s_sda_oe)
    else $error("device answered a foreign address");
  cover property (stop);
  cover property (nak);
  cover property (ign);
  cover property (ack_hi && slave_rx);
endmodule
`default_nettype wire

// >>> dim_master.sv
`timescale 1ns/1ps
`default_nettype none
module dim_master
  import dim_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int DEPTH  = 2,
  parameter int LEN_W  = 8
) (
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  dim_link_if.master             link,
  input  wire logic              req_valid_i,
  output logic                   req_ready_o,
  input  wire logic [6:0]        req_addr_i,
  input  wire logic              req_read_i,
  input  wire logic [LEN_W-1:0]  req_len_i,
  input  wire logic              tx_valid_i,
  output logic                   tx_ready_o,
  input  wire logic [DATA_W-1:0] tx_data_i,
  output logic                   rx_valid_o,
  output logic [DATA_W-1:0]      rx_data_o,
  output logic                   done_o,
  output logic                   nack_o
);
  localparam int QW = $clog2(DIM_QTR_CYC);
  localparam int PW = $clog2(DEPTH);
  if (DATA_W != 8 || DEPTH < 2 || DIM_QTR_CYC < 8) begin : g_chk
    $error("dim_master: unsupported parameters");
  end

  logic [1:0] s1_r, s2_r;
  logic scl_s, sda_s;
  dim_mst_state_t st_r, st_nxt;
  logic [1:0] ph_r, ph_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [QW-1:0] q_r, q_nxt;
  logic [7:0] sh_r, sh_nxt, rx_r, rx_nxt;
  logic [LEN_W-1:0] left_r, left_nxt;
  logic rd_r, rd_nxt, first_r, first_nxt, sclo_r, sclo_nxt;
  logic sdao_r, sdao_nxt, rdy_r, rdy_nxt, rxv_r, rxv_nxt;
  logic [7:0] rxd_r, rxd_nxt;
  logic done_r, done_nxt, nack_r, nack_nxt;
  logic [DATA_W-1:0] mem_r [DEPTH], mem_nxt [DEPTH];
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [PW:0] cnt_r, cnt_nxt;
  logic txr_r, txr_nxt, push, pop, qtick, rdata;

  assign scl_s = s2_r[1];
  assign sda_s = s2_r[0];
  assign link.m_scl_o  = 1'b0;
  assign link.m_sda_o  = 1'b0;
  assign link.m_scl_oe = sclo_r;
  assign link.m_sda_oe = sdao_r;
  assign req_ready_o = rdy_r;
  assign tx_ready_o  = txr_r;
  assign rx_valid_o  = rxv_r;
  assign rx_data_o   = rxd_r;
  assign done_o      = done_r;
  assign nack_o      = nack_r;
  assign rdata = rd_r & ~first_r;

  always_comb begin
    st_nxt = st_r; ph_nxt = ph_r; bit_nxt = bit_r; sh_nxt = sh_r;
    rx_nxt = rx_r; left_nxt = left_r; rd_nxt = rd_r;
    first_nxt = first_r; sclo_nxt = sclo_r; sdao_nxt = sdao_r;
    rdy_nxt = rdy_r; rxv_nxt = 1'b0; rxd_nxt = rxd_r;
    done_nxt = 1'b0; nack_nxt = nack_r; pop = 1'b0;
    qtick = (q_r == QW'(DIM_QTR_CYC - 1));
    q_nxt = qtick ? '0 : q_r + 1'b1;
    case (st_r)
      MS_IDLE: begin
        sclo_nxt = 1'b0;
        sdao_nxt = 1'b0;
        if (req_valid_i && rdy_r) begin
          rdy_nxt = 1'b0; sh_nxt = {req_addr_i, req_read_i};
          rd_nxt = req_read_i; left_nxt = req_len_i; first_nxt = 1'b1;
          nack_nxt = 1'b0; st_nxt = MS_START; ph_nxt = '0; q_nxt = '0;
        end
      end
      MS_START: if (qtick) begin
        if (ph_r == 2'd0) begin
          sdao_nxt = 1'b1; // [RULE12]
          ph_nxt = 2'd1;
        end else begin
          sclo_nxt = 1'b1; st_nxt = MS_BYTE; ph_nxt = '0; bit_nxt = '0;
        end
      end
      MS_BYTE: if (qtick) begin
        case (ph_r)
          2'd0: begin
            // Data changes only while the clock is low. [RULE13]
            if (bit_r == DIM_ACK_SLOT)
              sdao_nxt = rdata && (left_r != LEN_W'(1)); // [RULE6] [RULE8]
            else
              sdao_nxt = rdata ? 1'b0 : ~sh_r[7]; // [RULE3]
            ph_nxt = 2'd1;
          end
          2'd1: begin
            sclo_nxt = 1'b0; // [RULE4]
            if (scl_s) ph_nxt = 2'd2;
          end
          2'd2: begin
            ph_nxt = 2'd3;
            if (bit_r != DIM_ACK_SLOT) begin
              rx_nxt = {rx_r[6:0], sda_s};
            end else if (rdata) begin
              rxv_nxt = 1'b1; rxd_nxt = rx_r; left_nxt = left_r - 1'b1;
            end else begin
              nack_nxt = sda_s; // [RULE7]
            end
          end
          default: begin
            sclo_nxt = 1'b1;
            if (bit_r != DIM_ACK_SLOT) begin
              bit_nxt = bit_r + 1'b1; ph_nxt = '0; // [RULE2]
              if (!rdata) sh_nxt = {sh_r[6:0], 1'b0};
            end else if (!rdata && nack_r) begin
              st_nxt = MS_STOP; ph_nxt = '0;
            end else if (rd_r) begin
              first_nxt = 1'b0; bit_nxt = '0; ph_nxt = '0;
              if (left_r == '0) st_nxt = MS_STOP;
            end else if (left_r == '0) begin
              first_nxt = 1'b0; st_nxt = MS_STOP; ph_nxt = '0;
            end else if (cnt_r != '0) begin
              // Stalls with the clock held low until a byte is buffered.
              first_nxt = 1'b0; pop = 1'b1; sh_nxt = mem_r[rp_r];
              left_nxt = left_r - 1'b1; bit_nxt = '0; ph_nxt = '0;
            end
          end
        endcase
      end
      MS_STOP: if (qtick) begin
        ph_nxt = ph_r + 1'b1;
        case (ph_r)
          2'd0: sdao_nxt = 1'b1;
          2'd1: sclo_nxt = 1'b0;
          2'd2: sdao_nxt = 1'b0; // [RULE12]
          default: begin
            st_nxt = MS_IDLE; done_nxt = 1'b1; rdy_nxt = 1'b1;
          end
        endcase
      end
      default: st_nxt = MS_IDLE;
    endcase
  end

  always_comb begin
    push = tx_valid_i & txr_r;
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    if (push) begin
      mem_nxt[wp_r] = tx_data_i;
      wp_nxt = (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
    end
    if (pop) rp_nxt = (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
    cnt_nxt = cnt_r + (PW + 1)'(push) - (PW + 1)'(pop);
    txr_nxt = (cnt_nxt != (PW + 1)'(DEPTH));
  end

  always_ff @(posedge clock_i) begin
    s1_r <= {link.scl, link.sda};
    s2_r <= s1_r;
    mem_r <= mem_nxt;
    rxd_r <= rxd_nxt; rx_r <= rx_nxt; sh_r <= sh_nxt;
    if (rst_i) begin
      st_r <= MS_IDLE; ph_r <= '0; bit_r <= '0; q_r <= '0;
      left_r <= '0; rd_r <= 1'b0; first_r <= 1'b0;
      sclo_r <= 1'b0; sdao_r <= 1'b0; rdy_r <= 1'b1; rxv_r <= 1'b0;
      done_r <= 1'b0; nack_r <= 1'b0;
      wp_r <= '0; rp_r <= '0; cnt_r <= '0; txr_r <= 1'b1;
    end else begin
      st_r <= st_nxt; ph_r <= ph_nxt; bit_r <= bit_nxt; q_r <= q_nxt;
      left_r <= left_nxt; rd_r <= rd_nxt; first_r <= first_nxt;
      sclo_r <= sclo_nxt; sdao_r <= sdao_nxt; rdy_r <= rdy_nxt;
      rxv_r <= rxv_nxt; done_r <= done_nxt; nack_r <= nack_nxt;
      wp_r <= wp_nxt; rp_r <= rp_nxt; cnt_r <= cnt_nxt; txr_r <= txr_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> dim_pkg.sv
`default_nettype none
package dim_pkg;
  localparam int          DIM_CLK_NS        = 100;
  localparam int          DIM_SCL_PERIOD_NS = 10000;
  localparam int          DIM_QTR_CYC       =
    DIM_SCL_PERIOD_NS / (4 * DIM_CLK_NS);
  localparam logic [6:0]  DIM_ADDR_BASE     = 7'h60;
  localparam int          DIM_AI_BIT        = 4;
  localparam logic [3:0]  DIM_REG_FIRST     = 4'h2;
  localparam logic [3:0]  DIM_REG_LAST      = 4'h9;
  localparam logic [3:0]  DIM_REG_ZERO      = 4'h0;
  localparam int          DIM_NUM_REGS      = 8;
  localparam int          DIM_DUTY_FIRST    = 1;
  localparam int          DIM_DUTY_SECOND   = 3;
  localparam logic [7:0]  DIM_DUTY_RESET    = 8'h80;
  localparam logic [7:0]  DIM_ZERO_BYTE     = 8'h00;
  localparam logic [3:0]  DIM_LAST_BIT      = 4'h7;
  localparam logic [3:0]  DIM_ACK_SLOT      = 4'h8;
  typedef enum logic [2:0] {
    DS_IDLE, DS_ADDR, DS_CTRL, DS_WRITE, DS_READ, DS_IGNORE
  } dim_dev_state_t;
  typedef enum logic [1:0] {
    MS_IDLE, MS_START, MS_BYTE, MS_STOP
  } dim_mst_state_t;
endpackage
`default_nettype wire

// >>> dim_slave.sv
// Summary of operation
// [RULE1] No limit on bytes between start and stop.
// [RULE2] Eight data bits, then one acknowledge slot.
// [RULE3] Sender releases data line in acknowledge slot.
// [RULE4] Master clocks an extra acknowledge pulse.
// [RULE5] Addressed slave acknowledges every received byte.
// [RULE6] Master receiver acknowledges all but last byte.
// [RULE7] Acknowledger holds data low through clock high.
// [RULE8] Master ends read by not acknowledging.
// [RULE9] After no acknowledge, slave releases data line.
// [RULE10] Address pins low give write address C0h.
// [RULE11] Control 12h auto-increments through prescaler onwards.
// [RULE12] Data edges under high clock mark start/stop.
// [RULE13] Data stable while clock high; bit per pulse.
// [RULE14] Low reset pin holds registers and state.
// [RULE15] Wrong address: no acknowledge, ignore until start.
// [RULE16] Address bit zero: zero writes, one reads.
`timescale 1ns/1ps
`default_nettype none
module dim_slave
  import dim_pkg::*;
(
  input  wire logic  clock_i,
  input  wire logic  rst_i,
  dim_link_if.slave  link,
  input  wire logic  reset_pin_n_i,
  input  wire logic  address_select_pin_low_i,
  input  wire logic  address_select_pin_mid_i,
  input  wire logic  address_select_pin_high_i,
  output logic [7:0] blink_prescaler_first_o,
  output logic [7:0] blink_duty_first_o,
  output logic [7:0] blink_prescaler_second_o,
  output logic [7:0] blink_duty_second_o,
  output logic [7:0] led_source_select_group0_o,
  output logic [7:0] led_source_select_group1_o,
  output logic [7:0] led_source_select_group2_o,
  output logic [7:0] led_source_select_group3_o
);
  // Pin order: reset, select high, mid, low, clock line, data line.
  logic [5:0] s1_r, s2_r;
  logic scl_d_r, sda_d_r;
  logic scl_s, sda_s, hold, rise, fall, start, stop;
  logic [6:0] own_addr;
  dim_dev_state_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt, ptr_r, ptr_nxt;
  logic ai_r, ai_nxt, oe_r, oe_nxt;
  logic [7:0] sh_r, sh_nxt, tx_r, tx_nxt, rd_val;
  logic [7:0] regs_r [DIM_NUM_REGS], regs_nxt [DIM_NUM_REGS];

  assign hold     = ~s2_r[5];
  assign own_addr = DIM_ADDR_BASE | {4'h0, s2_r[4:2]}; // [RULE10]
  assign scl_s    = s2_r[1];
  assign sda_s    = s2_r[0];
  assign rise     = scl_s & ~scl_d_r;
  assign fall     = ~scl_s & scl_d_r;
  // Data edges while the clock stays high frame a transfer.
  assign start    = scl_s & scl_d_r & sda_d_r & ~sda_s; // [RULE12]
  assign stop     = scl_s & scl_d_r & ~sda_d_r & sda_s; // [RULE12]

  assign link.s_sda_o = 1'b0;
  assign link.s_sda_oe = oe_r;
  assign blink_prescaler_first_o    = regs_r[0];
  assign blink_duty_first_o         = regs_r[1];
  assign blink_prescaler_second_o   = regs_r[2];
  assign blink_duty_second_o        = regs_r[3];
  assign led_source_select_group0_o = regs_r[4];
  assign led_source_select_group1_o = regs_r[5];
  assign led_source_select_group2_o = regs_r[6];
  assign led_source_select_group3_o = regs_r[7];

  function automatic logic in_map(input logic [3:0] p);
    return (p >= DIM_REG_FIRST) && (p <= DIM_REG_LAST);
  endfunction

  // Pointer wraps from the last selector back to index zero.
  function automatic logic [3:0] advance(input logic [3:0] p,
                                         input logic       ai);
    if (!ai) return p;
    return (p == DIM_REG_LAST) ? DIM_REG_ZERO : p + 1'b1;
  endfunction

  // Indexes outside the writable map, pin inputs among them, read zero.
  always_comb begin
    rd_val = DIM_ZERO_BYTE;
    if (in_map(ptr_r)) rd_val = regs_r[3'(ptr_r - DIM_REG_FIRST)];
  end

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    ptr_nxt = ptr_r;
    ai_nxt = ai_r;
    oe_nxt = oe_r;
    sh_nxt = sh_r;
    tx_nxt = tx_r;
    regs_nxt = regs_r;
    if (start) begin
      // The clock fall that closes the start condition must not count as a
      // bit, so the counter parks in the slot that the next fall clears.
      st_nxt = DS_ADDR;
      cnt_nxt = DIM_ACK_SLOT; // [RULE2]
      oe_nxt = 1'b0;
    end else if (stop) begin
      st_nxt = DS_IDLE;
      oe_nxt = 1'b0;
    end else if (rise && cnt_r != DIM_ACK_SLOT) begin
      sh_nxt = {sh_r[6:0], sda_s}; // [RULE13]
    end else if (rise && st_r == DS_READ && sda_s) begin
      // Master withheld its acknowledge: stay off the line. [RULE9]
      st_nxt = DS_IGNORE;
      oe_nxt = 1'b0;
    end else if (fall && st_r != DS_IDLE && st_r != DS_IGNORE) begin
      if (cnt_r == DIM_LAST_BIT) begin
        cnt_nxt = DIM_ACK_SLOT; // [RULE2]
        oe_nxt = 1'b0;
        case (st_r)
          DS_ADDR: begin
            if (sh_r[7:1] == own_addr) begin
              oe_nxt = 1'b1; // [RULE5]
              st_nxt = sh_r[0] ? DS_READ : DS_CTRL; // [RULE16]
            end else begin
              st_nxt = DS_IGNORE; // [RULE15]
            end
          end
          DS_CTRL: begin
            ptr_nxt = sh_r[3:0]; // [RULE11]
            ai_nxt = sh_r[DIM_AI_BIT];
            oe_nxt = 1'b1; // [RULE5]
            st_nxt = DS_WRITE;
          end
          DS_WRITE: begin
            if (in_map(ptr_r)) regs_nxt[3'(ptr_r - DIM_REG_FIRST)] = sh_r;
            ptr_nxt = advance(ptr_r, ai_r); // [RULE11] [RULE1]
            oe_nxt = 1'b1; // [RULE5] [RULE7]
          end
          default: oe_nxt = 1'b0; // [RULE3]
        endcase
      end else if (cnt_r == DIM_ACK_SLOT) begin
        cnt_nxt = '0;
        oe_nxt = 1'b0; // [RULE3]
        if (st_r == DS_READ) begin
          tx_nxt = rd_val;
          oe_nxt = ~rd_val[7];
          ptr_nxt = advance(ptr_r, ai_r); // [RULE1]
        end
      end else begin
        cnt_nxt = cnt_r + 1'b1;
        if (st_r == DS_READ) begin
          tx_nxt = {tx_r[6:0], 1'b0};
          oe_nxt = ~tx_r[6];
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s1_r <= '1;
      s2_r <= '1;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      s1_r <= {reset_pin_n_i, address_select_pin_high_i,
               address_select_pin_mid_i, address_select_pin_low_i,
               link.scl, link.sda};
      s2_r <= s1_r;
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  always_ff @(posedge clock_i) begin
    sh_r <= sh_nxt;
    tx_r <= tx_nxt;
    if (rst_i || hold) begin // [RULE14]
      st_r <= DS_IDLE;
      cnt_r <= '0;
      ptr_r <= DIM_REG_ZERO;
      ai_r <= 1'b0;
      oe_r <= 1'b0;
      for (int i = 0; i < DIM_NUM_REGS; i++) begin
        regs_r[i] <= (i == DIM_DUTY_FIRST || i == DIM_DUTY_SECOND) ?
                     DIM_DUTY_RESET : DIM_ZERO_BYTE;
      end
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      ptr_r <= ptr_nxt;
      ai_r <= ai_nxt;
      oe_r <= oe_nxt;
      regs_r <= regs_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  mismatches++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module testbench;
  import dim_pkg::*;
  localparam logic [7:0] DFLT [8] = '{8'h00, 8'h80, 8'h00, 8'h80,
                                      8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] W1 [8] = '{8'h97, 8'h80, 8'h00, 8'h40,
                                    8'h55, 8'hFA, 8'h00, 8'h00};
  logic       clock_i, rst_i, reset_pin_n_i, req_valid_i, req_ready_o;
  logic       req_read_i, tx_valid_i, tx_ready_o, rx_valid_o;
  logic       done_o, nack_o;
  logic [6:0] req_addr_i;
  logic [7:0] req_len_i, tx_data_i, rx_data_o;
  logic [7:0] regs [8];
  logic [7:0] rxq [$];
  int         mismatches, n_checks;
  dim_link_if dim_link_if_i ();
  dim_master dim_master_i (.clock_i(clock_i), .rst_i(rst_i),
    .link(dim_link_if_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_addr_i(req_addr_i),
    .req_read_i(req_read_i), .req_len_i(req_len_i),
    .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
    .tx_data_i(tx_data_i), .rx_valid_o(rx_valid_o),
    .rx_data_o(rx_data_o), .done_o(done_o), .nack_o(nack_o));
  dim_slave dim_slave_i (.clock_i(clock_i), .rst_i(rst_i),
    .link(dim_link_if_i), .reset_pin_n_i(reset_pin_n_i),
    .address_select_pin_low_i(1'b0), .address_select_pin_mid_i(1'b0),
    .address_select_pin_high_i(1'b0),
    .blink_prescaler_first_o(regs[0]), .blink_duty_first_o(regs[1]),
    .blink_prescaler_second_o(regs[2]), .blink_duty_second_o(regs[3]),
    .led_source_select_group0_o(regs[4]),
    .led_source_select_group1_o(regs[5]),
    .led_source_select_group2_o(regs[6]),
    .led_source_select_group3_o(regs[7]));
  dim_link_monitor dim_link_monitor_i (.clock_i(clock_i), .rst_i(rst_i),
    .scl(dim_link_if_i.scl), .sda(dim_link_if_i.sda),
    .m_sda_oe(dim_link_if_i.m_sda_oe), .s_sda_oe(dim_link_if_i.s_sda_oe));
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    if (rx_valid_o === 1'b1) rxq.push_back(rx_data_o);
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk_regs(input logic [7:0] e [8]);
    for (int i = 0; i < 8; i++) `CHK("reg", e[i], regs[i])
  endtask
  // Bytes are pushed while the request runs; a gap starves the buffer.
  task automatic xfer(input logic [6:0] a, input logic r,
                      input logic [7:0] n, input logic [7:0] d [$],
                      input int gap);
    fork
      begin
        @(posedge clock_i);
        for (int k = 0; k < d.size(); k++) begin
          #1 tx_valid_i = 1'b1;
          tx_data_i = d[k];
          do @(posedge clock_i); while (tx_ready_o !== 1'b1);
          if (gap > 0) begin
            #1 tx_valid_i = 1'b0;
            repeat (gap) @(posedge clock_i);
          end
        end
        #1 tx_valid_i = 1'b0;
      end
      begin
        @(posedge clock_i);
        #1 req_valid_i = 1'b1;
        req_addr_i = a;
        req_read_i = r;
        req_len_i = n;
        do @(posedge clock_i); while (req_ready_o !== 1'b1);
        #1 req_valid_i = 1'b0;
        do @(posedge clock_i); while (done_o !== 1'b1);
      end
    join
  endtask
  initial begin
    repeat (60000) @(posedge clock_i);
    mismatches++;
    close_out();
  end
  initial begin
    {rst_i, reset_pin_n_i} = 2'b11;
    {req_valid_i, req_read_i, tx_valid_i} = 3'h0;
    req_addr_i = 7'h00;
    req_len_i = 8'h00;
    tx_data_i = 8'h00;
    repeat (4) @(posedge clock_i);
    #1 rst_i = 1'b0;
    chk_regs(DFLT);
    xfer(7'h60, 1'b0, 8'h09, '{8'h12, 8'h97, 8'h80, 8'h00, 8'h40, 8'h55,
         8'hFA, 8'h00, 8'h00}, 0);
    `CHK("nack", 1'b0, nack_o)
    chk_regs(W1);
    xfer(7'h60, 1'b0, 8'h01, '{8'h14}, 0);
    xfer(7'h60, 1'b1, 8'h03, '{}, 0);
    `CHK("rx count", 3, rxq.size())
    for (int i = 0; i < 3; i++) `CHK("rx", W1[i+2], rxq[i])
    xfer(7'h61, 1'b0, 8'h00, '{}, 0);
    `CHK("nack", 1'b1, nack_o)
    chk_regs(W1);
    #1 reset_pin_n_i = 1'b0;
    repeat (5) @(posedge clock_i);
    chk_regs(DFLT);
    #1 reset_pin_n_i = 1'b1;
    repeat (3) @(posedge clock_i);
    xfer(7'h60, 1'b0, 8'h02, '{8'h12, 8'h11}, 3000);
    chk_regs('{8'h11, 8'h80, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00,
               8'h00});
    close_out();
  end
endmodule
`default_nettype wire
